/* uic_defines.svh */
// Register offsets, bit positions and reset values of the serial port event block
`ifndef UIC_DEFINES_SVH
`define UIC_DEFINES_SVH
`define UIC_OFS_CTRL 12'h000
`define UIC_OFS_STAT 12'h004
`define UIC_OFS_TXBUF 12'h008
`define UIC_OFS_RXBUF 12'h00C
`define UIC_CTRL_SRST 0
`define UIC_CTRL_GIE 1
`define UIC_CTRL_TXIE 2
`define UIC_CTRL_RXIE 3
`define UIC_CTRL_RXEIE 4
`define UIC_CTRL_BRKIE 5
`define UIC_CTRL_DORM 6
`define UIC_CTRL_MODE_LO 7
`define UIC_CTRL_SMSEL 9
`define UIC_CTRL_W 10
`define UIC_CTRL_RST 10'h001
`define UIC_STAT_TXRDY 0
`define UIC_STAT_RXF 1
`define UIC_STAT_BRK 2
`define UIC_STAT_CRXF 3
`define UIC_STAT_CTXF 4
`define UIC_STAT_CREQ 5
`define UIC_STAT_IDLE 6
`endif

/* uic_pkg.sv */
// Types shared by the serial port event block
package uic_pkg;
   typedef enum logic [1:0] {
      UIC_PLAIN = 2'b00,
      UIC_IDLE_MP = 2'b01,
      UIC_ADDR_MP = 2'b10,
      UIC_AUTOBAUD = 2'b11
   } uic_mode_t;
endpackage : uic_pkg

/* uic_irq_clock_request.sv */
// Flag, interrupt vector and clock request logic of an asynchronous serial port
`timescale 1ns/1ns
`include "uic_defines.svh"

module uic_irq_clock_request #(
   parameter int CHAR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [CHAR_W-1:0] tx_data,
   output logic tx_valid,
   input wire logic tx_take,
   input wire logic tx_busy,
   input wire logic rx_load,
   input wire logic [CHAR_W-1:0] rx_data,
   input wire logic rx_err,
   input wire logic rx_addr,
   input wire logic rx_break,
   input wire logic rx_busy,
   input wire logic companion_rx_flag,
   input wire logic companion_rx_ie,
   input wire logic companion_tx_flag,
   input wire logic companion_tx_ie,
   input wire logic sub_main_stopped,
   output logic sub_main_clk_req,
   output logic rx_vector_req,
   output logic tx_vector_req
);
   import uic_pkg::*;

   logic [`UIC_CTRL_W-1:0] ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [CHAR_W-1:0] tx_buffer_q;
   logic tx_valid_q;
   logic tx_ready_flag_q;
   logic [CHAR_W-1:0] rx_buffer_q;
   logic rx_flag_q;
   logic break_status_q;
   logic clk_req_q;
   logic rx_vec_q;
   logic tx_vec_q;
   logic module_soft_reset;
   logic global_int_enable;
   logic tx_int_enable;
   logic rx_int_enable;
   logic rx_error_int_enable;
   logic break_int_enable;
   logic dormant_bit;
   logic sub_main_sel;
   uic_mode_t mode;
   logic acc_done;
   logic wr_done;
   logic rd_done;
   logic tx_write;
   logic rx_read;
   logic char_sets_flag;
   logic break_sets_flag;
   logic port_idle;

   // Characters travel in the low bits of one bus word, so 32 bits is the ceiling
   if (CHAR_W < 1 || CHAR_W > 32)
   begin : g_bad_char_w
      $error("CHAR_W must lie between 1 and 32");
   end

   // Returns true when the address selects one of the four words
   function automatic logic uic_mapped(input logic [11:0] a);
      uic_mapped = (a == `UIC_OFS_CTRL) || (a == `UIC_OFS_STAT) ||
                   (a == `UIC_OFS_TXBUF) || (a == `UIC_OFS_RXBUF);
   endfunction : uic_mapped

   // Control fields
   assign module_soft_reset = ctrl_q[`UIC_CTRL_SRST];
   assign global_int_enable = ctrl_q[`UIC_CTRL_GIE];
   assign tx_int_enable = ctrl_q[`UIC_CTRL_TXIE];
   assign rx_int_enable = ctrl_q[`UIC_CTRL_RXIE];
   assign rx_error_int_enable = ctrl_q[`UIC_CTRL_RXEIE];
   assign break_int_enable = ctrl_q[`UIC_CTRL_BRKIE];
   assign dormant_bit = ctrl_q[`UIC_CTRL_DORM];
   assign sub_main_sel = ctrl_q[`UIC_CTRL_SMSEL];
   assign mode = uic_mode_t'(ctrl_q[`UIC_CTRL_MODE_LO+1:`UIC_CTRL_MODE_LO]);

   // A transfer completes at the edge where pready is seen high
   assign acc_done = psel && penable && pready_q;
   assign wr_done = acc_done && pwrite && uic_mapped(paddr);
   assign rd_done = acc_done && !pwrite && uic_mapped(paddr);
   assign tx_write = wr_done && (paddr == `UIC_OFS_TXBUF);
   assign rx_read = rd_done && (paddr == `UIC_OFS_RXBUF);

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         pready_q <= 1'b0;
      else
         pready_q <= psel && penable && !pready_q;
   end

   // Unmapped addresses answer with an error and no effect
   always_ff @(posedge clk)
   begin
      if (srst)
         pslverr_q <= 1'b0;
      else
         pslverr_q <= psel && penable && !pready_q && !uic_mapped(paddr);
   end

   // Read data is prepared with pready so it is valid at the sampling edge
   always_ff @(posedge clk)
   begin
      if (srst)
         prdata_q <= 32'h0000_0000;
      else if (psel && penable && !pready_q && !pwrite)
      begin
         prdata_q <= 32'h0000_0000;
         case (paddr)
            `UIC_OFS_CTRL: prdata_q[`UIC_CTRL_W-1:0] <= ctrl_q;
            `UIC_OFS_STAT:
            begin
               prdata_q[`UIC_STAT_TXRDY] <= tx_ready_flag_q;
               prdata_q[`UIC_STAT_RXF] <= rx_flag_q;
               prdata_q[`UIC_STAT_BRK] <= break_status_q;
               prdata_q[`UIC_STAT_CRXF] <= companion_rx_flag;
               prdata_q[`UIC_STAT_CTXF] <= companion_tx_flag;
               prdata_q[`UIC_STAT_CREQ] <= clk_req_q;
               prdata_q[`UIC_STAT_IDLE] <= port_idle;
            end
            `UIC_OFS_TXBUF: prdata_q[CHAR_W-1:0] <= tx_buffer_q;
            `UIC_OFS_RXBUF: prdata_q[CHAR_W-1:0] <= rx_buffer_q;
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Control word; soft reset bit comes up set so the port starts held
   // tx enable cleared in soft reset
   // rx enable cleared in soft reset
   always_ff @(posedge clk)
   begin
      if (srst)
         ctrl_q <= `UIC_CTRL_RST;
      else
      begin
         if (wr_done && (paddr == `UIC_OFS_CTRL))
            ctrl_q <= pwdata[`UIC_CTRL_W-1:0];
         if (module_soft_reset ||
             (wr_done && (paddr == `UIC_OFS_CTRL) && pwdata[`UIC_CTRL_SRST]))
         begin
            ctrl_q[`UIC_CTRL_TXIE] <= 1'b0;
            ctrl_q[`UIC_CTRL_RXIE] <= 1'b0;
         end
      end
   end

   // Transmit buffer and its hand-off to the shifter
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_buffer_q <= '0;
         tx_valid_q <= 1'b0;
      end
      else if (module_soft_reset)
         tx_valid_q <= 1'b0;
      else if (tx_write)
      begin
         tx_buffer_q <= pwdata[CHAR_W-1:0];
         tx_valid_q <= 1'b1;
      end
      else if (tx_take)
         tx_valid_q <= 1'b0;
   end

   // Transmit-ready flag; a refill in the take cycle keeps it clear
   // because the buffer is occupied again
   always_ff @(posedge clk)
   begin
      // set by reset and soft reset
      if (srst || module_soft_reset)
         tx_ready_flag_q <= 1'b1;
      else if (tx_write)
         tx_ready_flag_q <= 1'b0;
      else if (tx_take)
         tx_ready_flag_q <= 1'b1;
   end

   // Qualifying a received character for the flag
   always_comb
   begin
      char_sets_flag = rx_load;
      if (rx_err && !rx_error_int_enable)
         char_sets_flag = 1'b0;
      if (dormant_bit)
      begin
         case (mode)
            UIC_IDLE_MP, UIC_ADDR_MP: char_sets_flag = char_sets_flag && rx_addr;
            default: char_sets_flag = 1'b0;
         endcase
      end
   end

   assign break_sets_flag = rx_break && break_int_enable;

   // Receive buffer loads on every character, qualified or not
   always_ff @(posedge clk)
   begin
      if (srst)
         rx_buffer_q <= '0;
      else if (rx_load)
         rx_buffer_q <= rx_data;
   end

   // Receive flag; an arriving character beats a same-cycle buffer read
   always_ff @(posedge clk)
   begin
      // cleared by reset and soft reset
      if (srst || module_soft_reset)
         rx_flag_q <= 1'b0;
      else if (char_sets_flag || break_sets_flag)
         rx_flag_q <= 1'b1;
      else if (rx_read)
         rx_flag_q <= 1'b0;
   end

   // Break status; cleared by a buffer read, a new break wins
   always_ff @(posedge clk)
   begin
      if (srst || module_soft_reset)
         break_status_q <= 1'b0;
      else if (break_sets_flag)
         break_status_q <= 1'b1;
      else if (rx_read)
         break_status_q <= 1'b0;
   end

   // Idle means no transmit byte buffered and neither shifter active
   assign port_idle = !tx_valid_q && !tx_busy && !rx_busy;

   // Clock request: only the sub-main source can be requested, so a port
   // running from the auxiliary clock never wakes anything
   // no auxiliary request
   always_ff @(posedge clk)
   begin
      if (srst || module_soft_reset)
         clk_req_q <= 1'b0;
      else
         clk_req_q <= sub_main_sel && !port_idle && (sub_main_stopped || clk_req_q);
   end

   // Interrupt vectors, each shared with the companion unit
   // two vectors only
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_vec_q <= 1'b0;
         tx_vec_q <= 1'b0;
      end
      else
      begin
         rx_vec_q <= global_int_enable &&
                     ((rx_flag_q && rx_int_enable) ||
                      (companion_rx_flag && companion_rx_ie));
         tx_vec_q <= global_int_enable &&
                     ((tx_ready_flag_q && tx_int_enable) ||
                      (companion_tx_flag && companion_tx_ie));
      end
   end

   assign sub_main_clk_req = clk_req_q;
   assign rx_vector_req = rx_vec_q;
   assign tx_vector_req = tx_vec_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_data = tx_buffer_q;
   assign tx_valid = tx_valid_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_tx_write_clears: assert property (tx_write && !module_soft_reset |=> !tx_ready_flag_q)
      else $error("tx ready flag not cleared by buffer write");
   a_tx_take_sets: assert property (tx_take && !tx_write |=> tx_ready_flag_q)
      else $error("tx ready flag not set when buffer freed");
   a_soft_tx_flag: assert property (module_soft_reset |=> tx_ready_flag_q && !tx_int_enable)
      else $error("soft reset did not force tx flag and enable");
   a_soft_rx_clear: assert property (module_soft_reset |=> !rx_flag_q && !rx_int_enable)
      else $error("soft reset did not clear rx flag and enable");
   a_rx_read_clears: assert property (rx_read && !char_sets_flag && !break_sets_flag
      && !module_soft_reset |=> !rx_flag_q)
      else $error("rx flag not cleared by buffer read");
   a_err_filtered: assert property (rx_err && !rx_error_int_enable && !rx_break
      && !rx_flag_q && !rx_read |=> !rx_flag_q)
      else $error("errored character set rx flag");
   a_dorm_plain: assert property (dormant_bit && mode == UIC_PLAIN && !rx_break
      && !rx_flag_q |=> !rx_flag_q)
      else $error("dormant plain mode character set rx flag");
   a_dorm_addr: assert property (dormant_bit && rx_load && rx_addr && !rx_err
      && (mode == UIC_ADDR_MP || mode == UIC_IDLE_MP) && !module_soft_reset |=> rx_flag_q)
      else $error("address character did not wake dormant receiver");
   a_break_sets: assert property (break_sets_flag && !module_soft_reset
      |=> rx_flag_q && break_status_q)
      else $error("break did not set status and rx flag");
   a_rx_vec_gate: assert property (rx_vec_q |-> $past(global_int_enable)
      && ($past(rx_flag_q && rx_int_enable) || $past(companion_rx_flag && companion_rx_ie)))
      else $error("receive vector without enabled flag");
   a_tx_vec_gate: assert property (global_int_enable && tx_ready_flag_q && tx_int_enable
      |=> tx_vec_q)
      else $error("transmit vector missing for enabled flag");
   a_req_idle: assert property (clk_req_q && !port_idle && sub_main_sel
      && !module_soft_reset |=> clk_req_q)
      else $error("clock request dropped before idle");
   a_req_release: assert property (port_idle |=> !clk_req_q)
      else $error("clock request held while idle");
   a_req_raise: assert property (sub_main_sel && sub_main_stopped && !port_idle
      && !module_soft_reset |=> sub_main_clk_req)
      else $error("stopped clock not requested");
   a_req_aux: assert property (!sub_main_sel |=> !sub_main_clk_req)
      else $error("clock requested while auxiliary source selected");

endmodule : uic_irq_clock_request

/* uic_line_peer.sv */
// Line-side model of the shift engines around the serial port event block
`timescale 1ns/1ns

module uic_line_peer (
   input wire logic clk,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_take,
   output logic tx_busy,
   output logic rx_load,
   output logic [7:0] rx_data,
   output logic rx_err,
   output logic rx_addr,
   output logic rx_break,
   output logic rx_busy
);
   int slow = 1;
   logic [7:0] last_tx = 8'h00;

   // Transmit engine: picks up the buffered byte, busy spans the take pulse
   initial
   begin
      tx_take = 1'b0;
      tx_busy = 1'b0;
      rx_load = 1'b0;
      rx_data = 8'h00;
      rx_err = 1'b0;
      rx_addr = 1'b0;
      rx_break = 1'b0;
      rx_busy = 1'b0;
      forever
      begin
         @(posedge clk);
         if (tx_valid === 1'b1)
         begin
            tx_busy <= 1'b1;
            repeat (slow) @(posedge clk);
            tx_take <= 1'b1;
            last_tx <= tx_data;
            @(posedge clk);
            tx_take <= 1'b0;
            repeat (slow) @(posedge clk);
            tx_busy <= 1'b0;
         end
      end
   end

   // Receive engine; after the load pulse the data and qualifiers flip so stale values never match
   task automatic recv(input logic [7:0] d, input logic e, input logic a, input logic b);
      @(posedge clk);
      rx_busy <= 1'b1;
      repeat (slow) @(posedge clk);
      rx_load <= ~b;
      rx_break <= b;
      rx_data <= d;
      rx_err <= e;
      rx_addr <= a;
      @(posedge clk);
      rx_load <= 1'b0;
      rx_break <= 1'b0;
      rx_data <= ~d;
      rx_err <= ~e;
      rx_addr <= ~a;
      rx_busy <= 1'b0;
   endtask : recv
endmodule : uic_line_peer

/* tb_uic_irq_clock_request.sv */
// Self-checking bench: flags, shared vectors and clock request of the serial port
`timescale 1ns/1ns
`include "uic_defines.svh"

module tb_uic_irq_clock_request;
   import uic_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, c;
   logic pready, pslverr, er, tx_valid, tx_take, tx_busy, rx_load, rx_err, rx_addr;
   logic rx_break, rx_busy, creq, rxv, txv, m_tx, m_rx, m_brk;
   logic [7:0] tx_data, rx_data;
   logic crxf = 1'b0;
   logic crxie = 1'b0;
   logic ctxf = 1'b0;
   logic ctxie = 1'b0;
   logic stopped = 1'b0;
   logic [31:0] m_ctrl = 32'h0000_0001;
   logic [31:0] seed = 32'h0000_b09b;
   logic [7:0] rxq[$];
   int bad_count = 0;
   int num_checks = 0;
   int k;

   uic_irq_clock_request u_uic_irq_clock_request (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_take(tx_take), .tx_busy(tx_busy), .rx_load(rx_load), .rx_data(rx_data),
      .rx_err(rx_err), .rx_addr(rx_addr), .rx_break(rx_break), .rx_busy(rx_busy),
      .companion_rx_flag(crxf), .companion_rx_ie(crxie), .companion_tx_flag(ctxf),
      .companion_tx_ie(ctxie), .sub_main_stopped(stopped), .sub_main_clk_req(creq),
      .rx_vector_req(rxv), .tx_vector_req(txv));
   uic_line_peer u_uic_line_peer (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_take(tx_take), .tx_busy(tx_busy), .rx_load(rx_load), .rx_data(rx_data),
      .rx_err(rx_err), .rx_addr(rx_addr), .rx_break(rx_break), .rx_busy(rx_busy));

   // 100 MHz clock
   always #5 clk = ~clk;

   // Watchdog, far beyond the fewer than a thousand cycles the sequence needs
   initial
   begin
      #200000;
      bad_count++;
      report_and_stop();
   end

   task automatic report_and_stop();
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      // The slave paces itself with one wait state; only the watchdog ends a stuck wait
      chk("pready_wait", 32'h2, 32'(n));
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Control write; soft reset forces the model's flags and enables as the port does
   // Enables written in the same word that leaves soft reset do not stick
   task automatic setc(input logic [31:0] v);
      m_ctrl = (v[0] || m_ctrl[0]) ? (v & ~32'h0000_000C) : v;
      apb(1'b1, `UIC_OFS_CTRL, v);
      if (v[0])
      begin
         m_tx = 1'b1;
         m_rx = 1'b0;
         m_brk = 1'b0;
      end
   endtask : setc

   // Flag readback, then both vectors once their lag has passed
   task automatic stat();
      apb(1'b0, `UIC_OFS_STAT, 32'h0);
      chk("stat", 32'({2'b10, ctxf, crxf, m_brk, m_rx, m_tx}), rd);
      repeat (3) @(posedge clk);
      chk("rxv", 32'(m_ctrl[1] & (m_rx & m_ctrl[3] | crxf & crxie)), 32'(rxv));
      chk("txv", 32'(m_ctrl[1] & (m_tx & m_ctrl[2] | ctxf & ctxie)), 32'(txv));
   endtask : stat

   initial
   begin
      m_tx = 1'b1;
      m_rx = 1'b0;
      m_brk = 1'b0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, `UIC_OFS_CTRL, 32'h0);
      chk("ctrl", 32'h0000_0001, rd);
      stat();
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", 32'h1, 32'(er));
      // First write leaves soft reset, second one makes the enables stick
      setc(32'h0000_020E);
      stat();
      setc(32'h0000_020E);
      stat();
      // Slow shifter with the sub-main clock stopped: request must span the whole send
      u_uic_line_peer.slow = 6;
      stopped <= 1'b1;
      apb(1'b1, `UIC_OFS_TXBUF, 32'h0000_005A);
      m_tx = 1'b0;
      repeat (3) @(posedge clk);
      chk("tx_data", 32'h5A, 32'(tx_data));
      chk("txv_clr", 32'h0, 32'(txv));
      k = 0;
      while ((tx_busy !== 1'b0 || tx_valid !== 1'b0) && k < 60)
      begin
         chk("creq_hold", 32'h1, 32'(creq));
         // Clock restarted mid-send: the request must still hold until idle
         if (k == 2)
            stopped <= 1'b0;
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      chk("tx_idle", 32'h0, 32'({tx_busy, tx_valid}));
      chk("creq_drop", 32'h0, 32'(creq));
      chk("peer_byte", 32'h5A, 32'(u_uic_line_peer.last_tx));
      m_tx = 1'b1;
      stat();
      // Random characters over every mode, dormant and error setting, companions too
      u_uic_line_peer.slow = 1;
      for (int i = 0; i < 32; i++)
      begin
         seed = xs(seed);
         c = {22'h0, 1'b0, seed[9:8], seed[10], 1'b1, seed[11], 4'b1110};
         setc(c);
         crxf <= seed[16];
         crxie <= seed[17];
         ctxf <= seed[18];
         ctxie <= seed[19];
         stopped <= seed[20];
         u_uic_line_peer.recv(seed[7:0], seed[12], seed[13], seed[14] & seed[15]);
         if (seed[14] & seed[15])
            m_brk = 1'b1;
         else
            rxq.push_back(seed[7:0]);
         if (m_brk || !(seed[12] && !c[4]) && !(c[6] && (!seed[13] ||
            uic_mode_t'(c[8:7]) inside {UIC_PLAIN, UIC_AUTOBAUD})))
            m_rx = 1'b1;
         stat();
         apb(1'b0, `UIC_OFS_RXBUF, 32'h0);
         if (rxq.size() > 0)
            chk("rxbuf", 32'(rxq.pop_front()), rd);
         m_rx = 1'b0;
         m_brk = 1'b0;
         stat();
      end
      // Mid-run reset returns control word and flags to their reset values
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      m_ctrl = 32'h0000_0001;
      apb(1'b0, `UIC_OFS_CTRL, 32'h0);
      chk("ctrl_rst", 32'h0000_0001, rd);
      stat();
      // Soft reset with a character pending and the global, tx and rx enables set
      crxf <= 1'b0;
      ctxf <= 1'b0;
      u_uic_line_peer.recv(8'hC3, 1'b0, 1'b0, 1'b0);
      setc(32'h0000_000F);
      apb(1'b0, `UIC_OFS_CTRL, 32'h0);
      chk("ctrl_en", 32'h1, 32'(rd[3:0] & 4'hD));
      stat();
      setc(32'h0000_000E);
      stat();
      setc(32'h0000_000E);
      stat();
      report_and_stop();
   end
endmodule : tb_uic_irq_clock_request
